// *** logic/conv_pkg.sv ***
// shared constants, types and register map of the converter control block
package conv_pkg;

  // widths
  localparam int RES_W = 10;
  localparam int CHAN_W = 6;
  localparam int DIV_W = 6;
  localparam int PREF_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_THRESH = 8'h14;

  // control word field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_CLKSRC = 3;
  localparam int CTRL_NREF = 4;
  localparam int CTRL_PREF_LSB = 5;
  localparam int CTRL_DIV_LSB = 8;

  // status and mask word field positions
  localparam int ST_DONE = 0;
  localparam int ST_THR = 1;
  localparam int ST_BUSY = 8;

  // reset values
  localparam logic [CHAN_W-1:0] CHAN_RST = 6'h00;
  localparam logic [PREF_W-1:0] PREF_RST = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [RES_W-1:0] THRESH_RST = 10'h3ff;

  // channel select codes
  localparam logic [CHAN_W-1:0] CH_PIN_LAST = 6'h17;
  localparam logic [CHAN_W-1:0] CH_GND = 6'h3c;
  localparam logic [CHAN_W-1:0] CH_TEMP = 6'h3d;
  localparam logic [CHAN_W-1:0] CH_DAC = 6'h3e;
  localparam logic [CHAN_W-1:0] CH_FVR = 6'h3f;

  // positive reference codes, above PREF_FVR4 is not a source
  localparam logic [PREF_W-1:0] PREF_PIN = 3'h0;
  localparam logic [PREF_W-1:0] PREF_SUPPLY = 3'h1;
  localparam logic [PREF_W-1:0] PREF_FVR1 = 3'h2;
  localparam logic [PREF_W-1:0] PREF_FVR2 = 3'h3;
  localparam logic [PREF_W-1:0] PREF_FVR4 = 3'h4;

  // conversion timing in half bit periods: 11.5 periods, 1.5 sampling
  localparam logic [4:0] HALF_CONV = 5'h17;
  localparam logic [4:0] HALF_SAMPLE = 5'h03;

  // source that the channel code connects
  typedef enum logic [2:0] {
    SRC_NONE, SRC_PIN, SRC_GND, SRC_TEMP, SRC_DAC, SRC_FVR
  } chan_src_e;

  // conversion sequencer states
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_e;

  // settings as seen by the converter side
  typedef struct packed {
    logic cont;
    logic neg_ref;
    logic [PREF_W-1:0] pos_ref;
    logic [CHAN_W-1:0] chan;
  } conv_cfg_s;

  // drive toward the analog front end
  typedef struct packed {
    chan_src_e src;
    logic connect;
    logic [CHAN_W-1:0] chan;
    logic [PREF_W-1:0] pos_ref;
    logic neg_ref;
    logic sample;
    logic [RES_W-1:0] trial;
  } analog_ctl_s;

endpackage

// *** logic/conv_tick_gen.sv ***
// half bit period tick from the rc clock pin or the oscillator divider
`timescale 1ns/1ps
module conv_tick_gen #(
  parameter int DIV_W = conv_pkg::DIV_W
) (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // clock choice
  input wire logic internal_rc_clock,
  input wire logic conv_clock_source_select,
  input wire logic [DIV_W-1:0] conv_clock_divider,
  // one pulse per half bit period
  output logic half_tick
);

  logic rc_s1_q; // first synchroniser stage
  logic rc_s2_q; // second synchroniser stage
  logic rc_s3_q; // edge history
  logic [DIV_W-1:0] div_cnt_q; // core clocks within a half period
  logic rc_edge; // either edge of the rc clock
  logic div_hit; // divider half period reached

  assign rc_edge = rc_s2_q ^ rc_s3_q;
  assign div_hit = div_cnt_q >= conv_clock_divider;

  // clock mux: each rc edge or each divider wrap is half a period
  assign half_tick = ce && (conv_clock_source_select ? rc_edge : div_hit);

  // bring the rc clock pin into the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else if (ce) begin
      rc_s1_q <= internal_rc_clock;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // field+1 core clocks per half, so the ratio is 2*field+2
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_q <= '0;
    end else if (ce) begin
      if (conv_clock_source_select || div_hit) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= DIV_W'(div_cnt_q + 1'b1);
      end
    end
  end

  chk_rc_only_ticks: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (conv_clock_source_select && !rc_edge) |-> !half_tick)
    else $error("tick without rc edge while rc clock chosen");

  // a rewrite of the divider field may legally retime the next tick
  chk_div_ratio: assert property (
    @(posedge core_clk) disable iff (!rst_n || !ce)
    (!conv_clock_source_select && half_tick && conv_clock_divider != '0)
      ##1 (!conv_clock_source_select && conv_clock_divider != '0)
      |-> !half_tick)
    else $error("divider ticked on consecutive cycles");

endmodule

// *** logic/conv_ctrl.sv ***
// converter control: registers, clock choice, sequencer and analog drive
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - ten bit successive approximation result stored
// - codes 0 to 0x17 select port pins
// - top codes select fixed reference, dac, temperature, ground
// - reserved channel codes connect nothing
// - positive reference from five sources
// - negative reference from pin or ground
// - source bit picks rc or oscillator
// - divider ratio is twice field plus two
// - conversion lasts eleven and half periods
// - control follows the chosen converter clock
// - done and threshold interrupts, both wake
// - done flag set on every completion
// - go cleared at completion unless continuous
module conv_ctrl #(
  parameter int RES_W = conv_pkg::RES_W,
  parameter int CHAN_W = conv_pkg::CHAN_W,
  parameter int DIV_W = conv_pkg::DIV_W
) (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog front end
  input wire logic internal_rc_clock,
  input wire logic cmp_in,
  output conv_pkg::analog_ctl_s ana_ctl,
  // interrupt and wake request
  output logic irq
);

  // bus phase tracking
  logic take; // address phase accepted
  logic [7:0] addr_q; // latched word address
  logic wr_ph_q; // write data phase
  logic rd_ph_q; // read wait cycle
  logic [31:0] hrdata_q; // read data
  logic [31:0] rd_val; // read mux

  // software registers
  logic en_q; // block enable
  logic go_q; // conversion_go
  logic cont_q; // continuous_conversion
  logic clksrc_q; // conv_clock_source_select
  logic nref_q; // neg_ref_select
  logic [2:0] pref_q; // pos_ref_select
  logic [DIV_W-1:0] div_q; // conv_clock_divider
  logic [CHAN_W-1:0] chan_q; // input_channel_select
  logic [1:0] mask_q; // interrupt mask
  logic [1:0] status_q; // sticky events
  logic [RES_W-1:0] thresh_q; // threshold level
  logic [RES_W-1:0] result_q; // conversion_result
  logic irq_q; // interrupt level

  // converter side
  conv_pkg::conv_cfg_s act_q; // settings taken on a converter tick
  conv_pkg::conv_state_e state_q; // sequencer state
  logic [4:0] cnt_q; // half periods since start
  logic [4:0] cnt_nx; // next half period count
  logic [RES_W-1:0] sar_q; // trial code
  logic [RES_W-1:0] tmask_q; // bit under test
  logic [RES_W-1:0] sar_dec; // trial after the comparator decision
  logic cmp_s1_q; // comparator synchroniser stage one
  logic cmp_s2_q; // comparator synchroniser stage two
  logic half_tick; // converter clock, half period
  logic done_pulse; // conversion finished this cycle
  logic [1:0] ev_set; // events raised this cycle
  logic [1:0] st_clr; // status bits read this cycle
  conv_pkg::analog_ctl_s ana_q; // registered analog drive

  // word address match
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    reg_hit = (a[7:2] == ofs[7:2]);
  endfunction

  // which source a channel code connects
  function automatic conv_pkg::chan_src_e chan_source(
    input logic [CHAN_W-1:0] c);
    chan_source = conv_pkg::SRC_NONE; // reserved codes
    if (c <= conv_pkg::CH_PIN_LAST) begin
      chan_source = conv_pkg::SRC_PIN;
    end else if (c == conv_pkg::CH_FVR) begin
      chan_source = conv_pkg::SRC_FVR;
    end else if (c == conv_pkg::CH_DAC) begin
      chan_source = conv_pkg::SRC_DAC;
    end else if (c == conv_pkg::CH_TEMP) begin
      chan_source = conv_pkg::SRC_TEMP;
    end else if (c == conv_pkg::CH_GND) begin
      chan_source = conv_pkg::SRC_GND;
    end
  endfunction

  // converter clock from rc pin or oscillator divider
  conv_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .internal_rc_clock(internal_rc_clock),
    .conv_clock_source_select(clksrc_q),
    .conv_clock_divider(div_q),
    .half_tick(half_tick)
  );

  // bus answer: writes take no wait, reads one wait cycle
  assign take = hsel && hready && htrans[1];
  assign hreadyout = !rd_ph_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq = irq_q;
  assign ana_ctl = ana_q;

  // sequencer arithmetic
  assign cnt_nx = 5'(cnt_q + 5'h01);
  assign sar_dec = cmp_s2_q ? sar_q : (sar_q & ~tmask_q);
  assign done_pulse = half_tick && state_q == conv_pkg::ST_CONV &&
                      en_q && go_q && cnt_nx == conv_pkg::HALF_CONV;
  assign ev_set[conv_pkg::ST_DONE] = done_pulse;
  assign ev_set[conv_pkg::ST_THR] = done_pulse && sar_dec >= thresh_q;
  assign st_clr = (rd_ph_q && reg_hit(addr_q, conv_pkg::OFS_STATUS)) ?
                  2'h3 : 2'h0;

  // bus phase capture
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
    end else if (ce) begin
      wr_ph_q <= take && hwrite;
      rd_ph_q <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_hit(addr_q, conv_pkg::OFS_CTRL)) begin
      rd_val[conv_pkg::CTRL_EN] = en_q;
      rd_val[conv_pkg::CTRL_GO] = go_q;
      rd_val[conv_pkg::CTRL_CONT] = cont_q;
      rd_val[conv_pkg::CTRL_CLKSRC] = clksrc_q;
      rd_val[conv_pkg::CTRL_NREF] = nref_q;
      rd_val[conv_pkg::CTRL_PREF_LSB +: 3] = pref_q;
      rd_val[conv_pkg::CTRL_DIV_LSB +: DIV_W] = div_q;
    end else if (reg_hit(addr_q, conv_pkg::OFS_CHAN)) begin
      rd_val[CHAN_W-1:0] = chan_q;
    end else if (reg_hit(addr_q, conv_pkg::OFS_RESULT)) begin
      rd_val[RES_W-1:0] = result_q;
    end else if (reg_hit(addr_q, conv_pkg::OFS_STATUS)) begin
      rd_val[1:0] = status_q;
      rd_val[conv_pkg::ST_BUSY] = state_q == conv_pkg::ST_CONV;
    end else if (reg_hit(addr_q, conv_pkg::OFS_MASK)) begin
      rd_val[1:0] = mask_q;
    end else if (reg_hit(addr_q, conv_pkg::OFS_THRESH)) begin
      rd_val[RES_W-1:0] = thresh_q;
    end
  end

  // read data loads in the wait cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && rd_ph_q) begin
      hrdata_q <= rd_val;
    end
  end

  // configuration writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      cont_q <= 1'b0;
      clksrc_q <= 1'b0;
      nref_q <= 1'b0;
      pref_q <= conv_pkg::PREF_RST;
      div_q <= conv_pkg::DIV_RST;
      chan_q <= conv_pkg::CHAN_RST;
      mask_q <= conv_pkg::MASK_RST;
      thresh_q <= conv_pkg::THRESH_RST;
    end else if (ce && wr_ph_q) begin
      if (reg_hit(addr_q, conv_pkg::OFS_CTRL)) begin
        en_q <= hwdata[conv_pkg::CTRL_EN];
        cont_q <= hwdata[conv_pkg::CTRL_CONT];
        clksrc_q <= hwdata[conv_pkg::CTRL_CLKSRC];
        nref_q <= hwdata[conv_pkg::CTRL_NREF];
        div_q <= hwdata[conv_pkg::CTRL_DIV_LSB +: DIV_W];
        // codes past the five sources fall back to the supply
        if (hwdata[conv_pkg::CTRL_PREF_LSB +: 3] > conv_pkg::PREF_FVR4) begin
          pref_q <= conv_pkg::PREF_SUPPLY;
        end else begin
          pref_q <= hwdata[conv_pkg::CTRL_PREF_LSB +: 3];
        end
      end
      if (reg_hit(addr_q, conv_pkg::OFS_CHAN)) begin
        chan_q <= hwdata[CHAN_W-1:0];
      end
      if (reg_hit(addr_q, conv_pkg::OFS_MASK)) begin
        mask_q <= hwdata[1:0];
      end
      if (reg_hit(addr_q, conv_pkg::OFS_THRESH)) begin
        thresh_q <= hwdata[RES_W-1:0];
      end
    end
  end

  // go bit: software write wins, completion clears it unless continuous
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      go_q <= 1'b0;
    end else if (ce) begin
      if (wr_ph_q && reg_hit(addr_q, conv_pkg::OFS_CTRL)) begin
        go_q <= hwdata[conv_pkg::CTRL_GO];
      end else if (done_pulse && !act_q.cont) begin
        go_q <= 1'b0;
      end
    end
  end

  // settings are taken only on a converter clock tick while idle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      act_q <= '0;
    end else if (half_tick && state_q == conv_pkg::ST_IDLE) begin
      act_q.cont <= cont_q;
      act_q.neg_ref <= nref_q;
      act_q.pos_ref <= pref_q;
      act_q.chan <= chan_q;
    end
  end

  // comparator pin synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else if (ce) begin
      cmp_s1_q <= cmp_in;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // successive approximation sequencer, one step per half period
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= conv_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sar_q <= '0;
      tmask_q <= '0;
    end else if (half_tick) begin
      case (state_q)
        conv_pkg::ST_IDLE: begin
          // continuous mode restarts here while go stays set
          if (en_q && go_q) begin
            state_q <= conv_pkg::ST_CONV;
            cnt_q <= 5'h00;
            sar_q <= '0;
            tmask_q <= '0;
          end
        end
        conv_pkg::ST_CONV: begin
          if (!en_q || !go_q) begin
            // abort: partial code dropped, result kept
            state_q <= conv_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_nx;
            if (cnt_nx == conv_pkg::HALF_SAMPLE) begin
              // sampling over, first trial on the top bit
              sar_q <= {1'b1, {(RES_W-1){1'b0}}};
              tmask_q <= {1'b1, {(RES_W-1){1'b0}}};
            end else if (cnt_nx > conv_pkg::HALF_SAMPLE && cnt_nx[0]) begin
              if (cnt_nx == conv_pkg::HALF_CONV) begin
                state_q <= conv_pkg::ST_IDLE;
              end else begin
                // keep or drop this bit, then try the next one
                sar_q <= sar_dec | (tmask_q >> 1);
                tmask_q <= tmask_q >> 1;
              end
            end
          end
        end
        default: begin
          state_q <= conv_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // result register updates only on completion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (done_pulse) begin
      result_q <= sar_dec;
    end
  end

  // sticky events, a status read clears, a new event wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_q <= 2'h0;
    end else if (ce) begin
      status_q <= (status_q & ~st_clr) | ev_set;
    end
  end

  // interrupt level also serves as the wake request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // analog drive from the settings in force
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ana_q <= '0;
    end else if (ce) begin
      ana_q.src <= chan_source(act_q.chan);
      ana_q.connect <= chan_source(act_q.chan) != conv_pkg::SRC_NONE;
      ana_q.chan <= act_q.chan;
      ana_q.pos_ref <= act_q.pos_ref;
      ana_q.neg_ref <= act_q.neg_ref;
      ana_q.sample <= state_q == conv_pkg::ST_CONV &&
                      cnt_q < conv_pkg::HALF_SAMPLE;
      ana_q.trial <= sar_q;
    end
  end

  chk_done_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    done_pulse |=> status_q[conv_pkg::ST_DONE])
    else $error("done flag not set after completion");

  chk_go_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (done_pulse && !act_q.cont && !wr_ph_q) |=> !go_q)
    else $error("go still set after single conversion");

  chk_go_cont: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (done_pulse && act_q.cont && !wr_ph_q) |=> go_q)
    else $error("go cleared in continuous mode");

  chk_reserved_open: assert property (
    @(posedge core_clk) disable iff (!rst_n || !ce)
    (act_q.chan > conv_pkg::CH_PIN_LAST && act_q.chan < conv_pkg::CH_GND)
      |=> !ana_q.connect)
    else $error("reserved channel code connected an input");

  chk_top_codes: assert property (
    @(posedge core_clk) disable iff (!rst_n || !ce)
    (act_q.chan == conv_pkg::CH_GND) |=> ana_q.src == conv_pkg::SRC_GND)
    else $error("ground code did not select ground");

  chk_pin_codes: assert property (
    @(posedge core_clk) disable iff (!rst_n || !ce)
    (act_q.chan <= conv_pkg::CH_PIN_LAST) |=> ana_q.src == conv_pkg::SRC_PIN)
    else $error("pin code did not select a pin");

  chk_conv_length: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    done_pulse |-> cnt_q == 5'h16 && tmask_q[0])
    else $error("conversion length not eleven and a half periods");

  chk_result_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !done_pulse |=> $stable(result_q))
    else $error("result changed without a completion");

  chk_cfg_sync: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (act_q.chan != $past(act_q.chan)) |-> $past(half_tick))
    else $error("settings moved off a converter tick");

  chk_irq_level: assert property (
    @(posedge core_clk) disable iff (!rst_n || !ce)
    (status_q[conv_pkg::ST_THR] && mask_q[conv_pkg::ST_THR]) |=> irq)
    else $error("unmasked threshold event raised no interrupt");

endmodule

// *** test/analog_front_model.sv ***
// behavioural analog front end: source levels and comparator
`timescale 1ns/1ps
module analog_front_model #(
  parameter logic [9:0] DAC_LVL = 10'h155, // plain default level
  parameter logic [9:0] TEMP_LVL = 10'h2aa, // plain default level
  parameter logic [9:0] FVR_LVL = 10'h333 // plain default level
) (
  // clock of the sampling side
  input wire logic core_clk,
  // drive from the control block
  input wire conv_pkg::analog_ctl_s ana_ctl,
  // comparator decision
  output logic cmp_in = 1'b0
);
  logic [9:0] level; // level on the hold node
  logic float_q = 1'b0; // an open input wanders every cycle

  // level of whichever source the code connects
  always_comb begin
    case (ana_ctl.src)
      conv_pkg::SRC_PIN: level = {ana_ctl.chan[4:0], 5'h0b};
      conv_pkg::SRC_TEMP: level = TEMP_LVL;
      conv_pkg::SRC_DAC: level = DAC_LVL;
      conv_pkg::SRC_FVR: level = FVR_LVL;
      default: level = 10'h000; // ground
    endcase
  end

  // comparator: high keeps the trial bit, open input gives no answer
  always @(posedge core_clk) begin
    float_q <= ~float_q;
    cmp_in <= ana_ctl.connect ? (level >= ana_ctl.trial) : float_q;
  end
endmodule

// *** test/adc_input_clock_config_bench.sv ***
// self-checking bench of the converter control block
`timescale 1ns/1ps
module adc_input_clock_config_bench;
  localparam logic [9:0] DAC_LVL = 10'h155; // dac source level
  localparam logic [9:0] TEMP_LVL = 10'h2aa; // temperature level
  localparam logic [9:0] FVR_LVL = 10'h333; // fixed reference level
  // clock, reset and bus
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, cmp_in;
  logic [31:0] hrdata;
  logic internal_rc_clock = 1'b0;
  conv_pkg::analog_ctl_s ana_ctl, snap; // drive and its sampled copy
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int smp = 0; // cycles with sampling shown, last conversion

  always #2 core_clk = ~core_clk; // 250 MHz
  always #17 internal_rc_clock = ~internal_rc_clock; // free rc clock

  conv_ctrl i_conv_ctrl (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .internal_rc_clock(internal_rc_clock), .cmp_in(cmp_in),
    .ana_ctl(ana_ctl), .irq(irq));

  analog_front_model #(.DAC_LVL(DAC_LVL), .TEMP_LVL(TEMP_LVL),
    .FVR_LVL(FVR_LVL)) i_analog_front_model (.core_clk(core_clk),
    .ana_ctl(ana_ctl), .cmp_in(cmp_in));

  // compare one value, count and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // counts and verdict, then stop
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'h2; // nonseq
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0; // idle while data stands
    hwdata <= wd;
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
    check(hresp, 1'b0); // response is always okay
  endtask

  // expected source level per channel code
  function automatic logic [9:0] lvl(input logic [5:0] c);
    case (c)
      conv_pkg::CH_GND: lvl = 10'h000;
      conv_pkg::CH_TEMP: lvl = TEMP_LVL;
      conv_pkg::CH_DAC: lvl = DAC_LVL;
      conv_pkg::CH_FVR: lvl = FVR_LVL;
      default: lvl = {c[4:0], 5'h0b};
    endcase
  endfunction

  // expected source per channel code
  function automatic conv_pkg::chan_src_e src_of(input logic [5:0] c);
    if (c <= conv_pkg::CH_PIN_LAST) src_of = conv_pkg::SRC_PIN;
    else if (c < conv_pkg::CH_GND) src_of = conv_pkg::SRC_NONE;
    else if (c == conv_pkg::CH_GND) src_of = conv_pkg::SRC_GND;
    else if (c == conv_pkg::CH_TEMP) src_of = conv_pkg::SRC_TEMP;
    else if (c == conv_pkg::CH_DAC) src_of = conv_pkg::SRC_DAC;
    else src_of = conv_pkg::SRC_FVR;
  endfunction

  // start a conversion, copy drive while sampling, time it to irq
  task automatic convert(input logic [31:0] ctl, output int cyc);
    wr(conv_pkg::OFS_CTRL, ctl);
    cyc = 0;
    smp = 0;
    do @(negedge core_clk); while (ana_ctl.sample !== 1'b1);
    snap = ana_ctl;
    while (irq !== 1'b1) begin
      cyc++;
      smp += (ana_ctl.sample === 1'b1);
      @(negedge core_clk);
    end
    @(posedge core_clk);
  endtask

  // reset values, unmapped word, plain write and read back
  task automatic test_reset();
    logic [31:0] d;
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), d);
      check(d, (a == 5) ? 32'h3ff : 32'h0);
    end
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, d);
    check(d, 32'h0);
    wr(conv_pkg::OFS_THRESH, 32'h155);
    rd(conv_pkg::OFS_THRESH, d);
    check(d, 32'h155);
    $display("test_reset finished");
  endtask

  // every kind of channel code, reference codes and divider values
  task automatic test_channels();
    logic [5:0] codes [8] = '{6'h00, 6'h17, 6'h18, 6'h3b,
                              6'h3c, 6'h3d, 6'h3e, 6'h3f};
    logic [31:0] d;
    logic [5:0] f;
    logic conn;
    int cyc;
    wr(conv_pkg::OFS_MASK, 32'h3);
    wr(conv_pkg::OFS_THRESH, 32'h200);
    for (int i = 0; i < 8; i++) begin
      f = (i == 7) ? 6'h3f : 6'(i % 4 + 3);
      conn = (src_of(codes[i]) != conv_pkg::SRC_NONE);
      wr(conv_pkg::OFS_CHAN, {26'h0, codes[i]});
      repeat (8) @(posedge core_clk); // settle after a new channel
      convert({18'h0, f, 3'(i), i[0], 4'h3}, cyc);
      check(32'(snap.src), 32'(src_of(codes[i])));
      check({snap.connect, snap.chan}, {conn, codes[i]});
      check(snap.pos_ref, (i > 4) ? 3'h1 : 3'(i));
      check(snap.neg_ref, i[0]);
      check(cyc, 23 * (f + 1));
      check(smp, 3 * (f + 1));
      rd(conv_pkg::OFS_STATUS, d);
      check(d & (conn ? 32'h103 : 32'h101),
            conn ? {30'h0, lvl(codes[i]) >= 10'h200, 1'b1} : 32'h1);
      rd(conv_pkg::OFS_STATUS, d);
      check(d & 32'h3, 32'h0);
      rd(conv_pkg::OFS_CTRL, d);
      check(d[1], 1'b0);
      if (conn) begin
        rd(conv_pkg::OFS_RESULT, d);
        check(d, {22'h0, lvl(codes[i])});
      end
    end
    $display("test_channels finished");
  endtask

  // conversion timed by the rc clock
  task automatic test_rc();
    logic [31:0] d;
    int cyc;
    wr(conv_pkg::OFS_CHAN, {26'h0, conv_pkg::CH_DAC});
    repeat (8) @(posedge core_clk);
    convert(32'h0000_000b, cyc); // rc source, as for sleep
    check(cyc >= 90 && cyc <= 106, 1'b1);
    rd(conv_pkg::OFS_STATUS, d);
    rd(conv_pkg::OFS_RESULT, d);
    check(d, {22'h0, DAC_LVL});
    $display("test_rc finished");
  endtask

  // masked flag, continuous restart, abort keeps the result
  task automatic test_irq();
    logic [31:0] d;
    logic [31:0] prev;
    int cyc;
    int seen;
    wr(conv_pkg::OFS_MASK, 32'h0);
    wr(conv_pkg::OFS_CTRL, 32'h0000_0303);
    seen = 0;
    repeat (150) begin
      @(negedge core_clk);
      seen += (irq !== 1'b0);
    end
    @(posedge core_clk);
    check(seen, 0);
    rd(conv_pkg::OFS_STATUS, d);
    check(d & 32'h101, 32'h1);
    wr(conv_pkg::OFS_MASK, 32'h1);
    convert(32'h0000_0307, cyc);
    rd(conv_pkg::OFS_CTRL, d);
    check(d[2:1], 2'h3);
    rd(conv_pkg::OFS_STATUS, d);
    seen = 0;
    repeat (120) begin
      @(negedge core_clk);
      seen += (irq === 1'b1);
    end
    @(posedge core_clk);
    check(seen > 0, 1'b1);
    wr(conv_pkg::OFS_CTRL, 32'h0);
    repeat (8) @(posedge core_clk);
    rd(conv_pkg::OFS_STATUS, d);
    rd(conv_pkg::OFS_RESULT, prev);
    wr(conv_pkg::OFS_CHAN, {26'h0, conv_pkg::CH_GND});
    repeat (8) @(posedge core_clk);
    wr(conv_pkg::OFS_CTRL, 32'h0000_0303);
    do @(negedge core_clk); while (ana_ctl.sample !== 1'b1);
    repeat (20) @(posedge core_clk); // let sampling end
    wr(conv_pkg::OFS_CTRL, 32'h1); // abort on the grounded input
    repeat (120) @(posedge core_clk);
    rd(conv_pkg::OFS_STATUS, d);
    check(d, 32'h0);
    rd(conv_pkg::OFS_RESULT, d);
    check(d, prev);
    $display("test_irq finished");
  endtask

  // reset, scenarios, verdict
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk); // reset values still stand here
    check(32'(ana_ctl.src), 32'(conv_pkg::SRC_NONE));
    check({hreadyout, irq}, 2'h2);
    @(posedge core_clk);
    test_reset();
    test_channels();
    test_rc();
    test_irq();
    complete_run();
  end
endmodule
